// File: src/clk_presc_pkg.sv
// constants for the system clock and prescaler block
// assumes a single 100 MHz reference clock domain
package clk_presc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SETTLE_US = 500;
  localparam int unsigned SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam int unsigned RESW_CYCLES = 10;
  localparam int unsigned DUTY_MIN_MHZ = 5;
  localparam int unsigned PRESC_W = 12;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PER_W = 8;
  localparam logic [PRESC_W-1:0] PRESC_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [PER_W-1:0] PER_ZERO = 8'h00;
  localparam logic [PER_W-1:0] PER_ONE = 8'h01;
  // period at 5 MHz in reference cycles
  localparam logic [PER_W-1:0] DUTY_PER_LIM =
    PER_W'(CLK_MHZ / DUTY_MIN_MHZ);
endpackage : clk_presc_pkg

// File: src/presc_counter.sv
// free running prescaler counter, advanced by peripheral clock ticks
// assumes tick is a one-cycle pulse in the system clock domain
`timescale 1ns/1ps
module presc_counter
  import clk_presc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  output logic [PRESC_W-1:0] o_taps
);
  logic [PRESC_W-1:0] cnt_reg;
  logic [PRESC_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (i_tick) begin
      cnt_next = cnt_reg + PRESC_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= PRESC_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // stage k toggles at periph / 2^(k+1)
  assign o_taps = cnt_reg;
endmodule : presc_counter

// File: src/system_clock_prescaler.sv
// system clock forming, peripheral halving and prescaler taps
// assumes ext clock input is sampled synchronously to i_sys_clk
`timescale 1ns/1ps
module system_clock_prescaler
  import clk_presc_pkg::*;
#(
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES
)
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_ext_clock_in,
  input wire logic i_chip_init_pin_n,
  input wire logic i_clock_halving_select,
  output logic o_crystal_drive_out,
  output logic o_sys_clk_tick,
  output logic o_sys_clk_level,
  output logic o_periph_tick,
  output logic o_clock_valid,
  output logic o_duty_active,
  output logic [PRESC_W-1:0] o_presc_taps
);
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_SETTLE = 3'b010,
    ST_VALID = 3'b100
  } settle_state_t;

  function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
    inc_sat = (v == {CNT_W{1'b1}}) ? v : v + CNT_ONE;
  endfunction : inc_sat

  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_n;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // edge detect and period measurement of the ext clock
  logic ext_d_reg;
  logic ext_d_next;
  logic [PER_W-1:0] per_cnt_reg;
  logic [PER_W-1:0] per_cnt_next;
  logic [PER_W-1:0] per_len_reg;
  logic [PER_W-1:0] per_len_next;
  logic [PER_W-1:0] phase_reg;
  logic [PER_W-1:0] phase_next;
  logic sys_lvl_reg;
  logic sys_lvl_next;
  logic duty_reg;
  logic duty_next;
  logic rise;

  assign rise = i_ext_clock_in & ~ext_d_reg;

  always_comb begin
    ext_d_next = i_ext_clock_in;
    per_cnt_next = per_cnt_reg;
    per_len_next = per_len_reg;
    phase_next = phase_reg + PER_ONE;
    duty_next = duty_reg;
    sys_lvl_next = i_ext_clock_in;
    if (per_cnt_reg != {PER_W{1'b1}}) begin
      per_cnt_next = per_cnt_reg + PER_ONE;
    end
    if (rise) begin
      per_len_next = per_cnt_reg + PER_ONE;
      per_cnt_next = PER_ZERO;
      phase_next = PER_ZERO;
      duty_next = per_cnt_reg < DUTY_PER_LIM;
    end
    if (duty_reg) begin
      // high for first half of the measured period
      sys_lvl_next = rise | (phase_next < (per_len_reg >> 1));
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_d_reg <= 1'b1; // idle level of the pin, no false edge
      per_cnt_reg <= PER_ZERO;
      per_len_reg <= PER_ZERO;
      phase_reg <= PER_ZERO;
      sys_lvl_reg <= 1'b0;
      duty_reg <= 1'b0;
    end else begin
      ext_d_reg <= ext_d_next;
      per_cnt_reg <= per_cnt_next;
      per_len_reg <= per_len_next;
      phase_reg <= phase_next;
      sys_lvl_reg <= sys_lvl_next;
      duty_reg <= duty_next;
    end
  end

  // settle supervision
  settle_state_t st_reg;
  settle_state_t st_next;
  logic [CNT_W-1:0] settle_reg;
  logic [CNT_W-1:0] settle_next;

  always_comb begin
    st_next = st_reg;
    settle_next = settle_reg;
    case (st_reg)
      ST_WAIT: begin
        settle_next = CNT_ZERO;
        if (rise) begin
          st_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (rise) begin
          settle_next = inc_sat(settle_reg);
        end
        if (32'(settle_reg) >= SETTLE_CNT) begin
          st_next = ST_VALID;
        end
      end
      ST_VALID: begin
        st_next = ST_VALID;
      end
      default: begin
        st_next = ST_WAIT;
        settle_next = CNT_ZERO;
      end
    endcase
  end

  // settle state, cleared only by reset
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_WAIT;
      settle_reg <= CNT_ZERO;
    end else begin
      st_reg <= st_next;
      settle_reg <= settle_next;
    end
  end

  // peripheral tick: every rise or every other rise
  logic half_reg;
  logic half_next;
  logic per_tick_reg;
  logic per_tick_next;
  logic valid;
  logic run;

  assign valid = (st_reg == ST_VALID);
  assign run = valid & i_chip_init_pin_n;

  always_comb begin
    half_next = half_reg;
    per_tick_next = 1'b0;
    if (run && rise) begin
      half_next = ~half_reg;
      per_tick_next = i_clock_halving_select ? half_reg : 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_reg <= 1'b0;
      per_tick_reg <= 1'b0;
    end else begin
      half_reg <= half_next;
      per_tick_reg <= per_tick_next;
    end
  end

  presc_counter u_presc (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_tick(per_tick_reg),
    .o_taps(o_presc_taps)
  );

  logic sys_tick_reg;
  logic sys_tick_next;

  always_comb begin
    sys_tick_next = run & rise;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_tick_reg <= 1'b0;
    end else begin
      sys_tick_reg <= sys_tick_next;
    end
  end

  // level output, held low until the clock is confirmed
  logic lvl_out_reg;
  logic lvl_out_next;

  always_comb begin
    lvl_out_next = sys_lvl_reg & valid;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_out_reg <= 1'b0;
    end else begin
      lvl_out_reg <= lvl_out_next;
    end
  end

  // crystal drive unused with ext clock, held low (external high in standby)
  assign o_crystal_drive_out = 1'b0;
  assign o_sys_clk_tick = sys_tick_reg;
  assign o_sys_clk_level = lvl_out_reg;
  assign o_periph_tick = per_tick_reg;
  assign o_clock_valid = valid;
  assign o_duty_active = duty_reg;
endmodule : system_clock_prescaler

// File: verif/presc_monitor.sv
// checker on the clock prescaler top ports
// assumes bind onto system_clock_prescaler
`timescale 1ns/1ps
module presc_monitor
  import clk_presc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_ext_clock_in,
  input wire logic i_clock_halving_select,
  input wire logic o_sys_clk_tick,
  input wire logic o_periph_tick,
  input wire logic o_clock_valid,
  input wire logic [PRESC_W-1:0] o_presc_taps
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  sequence ext_rise;
    $past(i_ext_clock_in) && !$past(i_ext_clock_in, 2);
  endsequence
  sequence half_gap;
    o_periph_tick ##1 !o_sys_clk_tick [*3] ##1 o_sys_clk_tick;
  endsequence
  chk_quiet_early: assert property (
    !o_clock_valid |-> !o_sys_clk_tick && !o_periph_tick)
    else $error("tick before valid");
  chk_valid_holds: assert property (
    $past(o_clock_valid) |-> o_clock_valid) else $error("valid dropped");
  chk_tick_cause: assert property (
    o_sys_clk_tick |-> ext_rise) else $error("tick without rise");
  chk_full_rate: assert property (
    o_sys_clk_tick && !i_clock_halving_select
    && !$past(i_clock_halving_select) |-> o_periph_tick)
    else $error("periph tick missing");
  chk_half_skip: assert property (
    (i_clock_halving_select throughout half_gap) |-> !o_periph_tick)
    else $error("periph not halved");
  chk_taps_step: assert property (
    o_presc_taps == $past(o_presc_taps) + PRESC_W'($past(o_periph_tick)))
    else $error("taps step wrong");
endmodule : presc_monitor
bind system_clock_prescaler presc_monitor u_mon (.*);

// File: verif/ext_clk_src.sv
// external clock source and board init pin model
// assumes the reference clock as its time base
`timescale 1ns/1ps
module ext_clk_src (
  input wire logic i_sys_clk,
  input wire logic i_run,
  input wire logic [7:0] i_half,
  output logic o_ext,
  output logic o_init_n
);
  logic [7:0] ph_reg = 8'h00;
  logic [3:0] rise_reg = 4'h0;
  initial begin
    o_ext = 1'b1;
    o_init_n = 1'b0;
  end
  always @(posedge i_sys_clk) begin
    if (!i_run) begin
      o_ext <= 1'b1;
      ph_reg <= 8'h00;
    end else if (ph_reg + 8'h01 >= i_half) begin
      o_ext <= !o_ext;
      ph_reg <= 8'h00;
      if (!o_ext && rise_reg < 4'ha) rise_reg <= rise_reg + 4'h1;
    end else ph_reg <= ph_reg + 8'h01;
    o_init_n <= (rise_reg == 4'ha);
  end
endmodule : ext_clk_src

// File: verif/tb.sv
// self-checking bench for system_clock_prescaler
// assumes ext_clk_src as partner and the bound monitor
`timescale 1ns/1ps
module tb;
  import clk_presc_pkg::*;
  typedef struct {logic [7:0] half; logic sel; logic duty;} row_t;
  row_t rows [4] = '{'{8'h02, 1'b0, 1'b1}, '{8'h02, 1'b1, 1'b1},
    '{8'h0a, 1'b1, 1'b1}, '{8'h0f, 1'b0, 1'b0}};
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic run = 1'b0;
  logic gate = 1'b1;
  logic sel = 1'b0;
  logic [7:0] half = 8'h02;
  logic ext, init_n, stick, ptick, valid, duty, lvl, xdrv;
  logic [PRESC_W-1:0] taps, t0;
  int fail_count = 0;
  int checks_done = 0;
  int ns, np, nl;
  ext_clk_src u_src (.i_sys_clk(i_sys_clk), .i_run(run), .i_half(half),
    .o_ext(ext), .o_init_n(init_n));
  system_clock_prescaler #(.SETTLE_CNT(4)) u_dut (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_ext_clock_in(ext),
    .i_chip_init_pin_n(init_n & gate), .i_clock_halving_select(sel),
    .o_crystal_drive_out(xdrv), .o_sys_clk_tick(stick), .o_sys_clk_level(lvl),
    .o_periph_tick(ptick), .o_clock_valid(valid), .o_duty_active(duty),
    .o_presc_taps(taps));
  initial forever #5 i_sys_clk = !i_sys_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("mismatches %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic count(input int n);
    ns = 0;
    np = 0;
    nl = 0;
    repeat (n) begin
      @(posedge i_sys_clk);
      ns += stick;
      np += ptick;
      nl += lvl;
    end
  endtask : count
  initial begin
    #100us;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    check(valid, 1'b0);
    check(xdrv, 1'b0);
    run <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    check(valid, 1'b0);
    repeat (40) @(posedge i_sys_clk);
    check(valid, 1'b1);
    foreach (rows[i]) begin
      half <= rows[i].half;
      sel <= rows[i].sel;
      repeat (100) @(posedge i_sys_clk);
      t0 = taps;
      count(32 * rows[i].half);
      check(duty, rows[i].duty);
      check(16'(ns), 16'h0010);
      check(16'(np), rows[i].sel ? 16'h0008 : 16'h0010);
      check(16'(taps - t0), 16'(np));
      check(16'(nl), 16'(16 * rows[i].half));
    end
    gate <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    count(64);
    check(16'(ns), 16'h0000);
    check(valid, 1'b1);
    run <= 1'b0;
    gate <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    count(64);
    check(16'(ns), 16'h0000);
    i_nrst <= 1'b0;
    @(posedge i_sys_clk);
    check(valid, 1'b0);
    check(lvl, 1'b0);
    check(16'(taps), 16'h0000);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    check(valid, 1'b0);
    run <= 1'b1;
    repeat (300) @(posedge i_sys_clk);
    check(valid, 1'b1);
    count(480);
    check(16'(ns), 16'h0010);
    check(16'(np), 16'h0010);
    complete_run();
  end
endmodule : tb
